// *** rtl/pcc_pkg.sv ***
// constants, types and functions for the pll core clock control block
// Function
// [R1] system clock is a PLL locked at 512 times the crystal frequency
// [R2] after power-on the core runs at the PLL clock divided by 8
// [R3] core rate is source over two to the divider field, rewritable anytime
// [R4] modulator clock ticks at crystal rate, synchronous with core ticks
// [R5] software should never program divider zero on low-supply parts
// [R6] on direct-crystal variant software writes non-divider bits as zero
// [R7] control bit 7 set halts the 32 kHz oscillator in power-down
// [R8] control bit 7 clear keeps the oscillator running in power-down
// [R9] control bit 6 is a read-only lock flag, writes ignored
// [R10] lock flag set while tracking the crystal; output rails without it
// [R11] lock flag cleared when not tracking, e.g. no crystal at power-on; code resets it set and clears it at PERIOD_TIMEOUT or on an out-of-window crystal edge
// [R12] divider in bits 2..0; 0,1,2 give 16.78, 8.39, 4.19 MHz, halving
// [R13] bit 3 runs interrupt service at fastest clock, then resumes divider
// [R14] divider changes land on a divided-clock boundary, no runt pulses
// [R15] reserved control bits have no behavioural effect
package pcc_pkg;

	// register placement and layout
	localparam logic [7:0] CLOCK_CONTROL_REG_ADDR = 8'hD7;
	localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h53;
	localparam int BIT_OSC_HALT = 7;
	localparam int BIT_LOCK = 6;
	localparam int BIT_RSVD_HI = 5;
	localparam int BIT_RSVD_LO = 4;
	localparam int BIT_FAST_IRQ = 3;
	localparam int BIT_DIV_HI = 2;

	// timing in PLL clock cycles
	localparam int XTAL_MULT = 512;
	localparam logic [8:0] MOD_LAST = 9'h1FF;
	localparam logic [9:0] LOCK_TOL = 10'h008;
	localparam logic [9:0] PERIOD_NOM = 10'h200;
	localparam logic [9:0] PERIOD_TIMEOUT = 10'h3FF;

	// special-function-register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} pcc_sfr_req_t;

	// low bits that must be all ones before a divided tick
	function automatic logic [6:0] pcc_div_mask(input logic [2:0] div);
		pcc_div_mask = 7'(({7'h00, 1'b1} << div) - 8'h01);
	endfunction

endpackage

// *** rtl/pcc_xtal_sync.sv ***
// crystal pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
module pcc_xtal_sync
	import pcc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// crystal pin and qualified edge
	input wire logic xtal_in,
	output logic xtal_rise
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	logic rise_ff;

	always_ff @(posedge clock) begin
		s1_ff <= xtal_in;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
	end

	// a new level counts only once the second and third stages agree
	always_ff @(posedge clock) begin
		if (rst) begin
			level_ff <= 1'b0;
			rise_ff <= 1'b0;
		end else begin
			rise_ff <= 1'b0;
			if (s2_ff == s3_ff) begin
				level_ff <= s3_ff;
				rise_ff <= s3_ff & ~level_ff;
			end
		end
	end

	assign xtal_rise = rise_ff;

endmodule

// *** rtl/pcc_clock_control.sv ***
// clock control: divider, modulator tick, lock detect, control register
`timescale 1ns/100ps
module pcc_clock_control
	import pcc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register access
	input wire pcc_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata_ff,
	// core status
	input wire logic irq_active,
	input wire logic powerdown,
	// crystal pin
	input wire logic xtal_in,
	// clock outputs
	output logic core_tick_ff,
	output logic [2:0] core_div_ff,
	output logic mod_tick_ff,
	output logic osc_run_ff,
	output logic pll_railed_ff
);

	logic halt_ff;
	logic [1:0] rsvd_ff;
	logic fast_irq_response_ff;
	logic [2:0] cd_ff;
	logic lock_ff;
	logic [6:0] core_cnt_ff;
	logic [8:0] mod_cnt_ff;
	logic [9:0] period_ff;
	logic xtal_rise;
	logic reg_hit;
	logic core_wrap;
	logic [2:0] nxt_div;
	logic in_window;

	assign reg_hit = (sfr_req.addr == CLOCK_CONTROL_REG_ADDR);
	assign core_wrap = (core_cnt_ff == pcc_div_mask(core_div_ff));
	assign nxt_div = (fast_irq_response_ff && irq_active) ? 3'h0 : cd_ff; // [R13]
	assign in_window = (period_ff >= PERIOD_NOM - LOCK_TOL) &&
		(period_ff <= PERIOD_NOM + LOCK_TOL);

	pcc_xtal_sync u_sync (
		.clock(clock),
		.rst(rst),
		.xtal_in(xtal_in),
		.xtal_rise(xtal_rise)
	);

	////////////////////////////////////////////////////////////////////////
	// control register writes; lock bit is not writable
	always_ff @(posedge clock) begin
		if (rst) begin
			halt_ff <= CLOCK_CONTROL_RESET[BIT_OSC_HALT];
			rsvd_ff <= CLOCK_CONTROL_RESET[BIT_RSVD_HI:BIT_RSVD_LO];
			fast_irq_response_ff <= CLOCK_CONTROL_RESET[BIT_FAST_IRQ];
			cd_ff <= CLOCK_CONTROL_RESET[BIT_DIV_HI:0]; // [R2]
		end else if (sfr_req.wr && reg_hit) begin
			halt_ff <= sfr_req.wdata[BIT_OSC_HALT];
			// stored for readback only, steer nothing
			rsvd_ff <= sfr_req.wdata[BIT_RSVD_HI:BIT_RSVD_LO]; // [R15]
			fast_irq_response_ff <= sfr_req.wdata[BIT_FAST_IRQ];
			// zero is accepted; keeping off it is software's job
			cd_ff <= sfr_req.wdata[BIT_DIV_HI:0]; // [R12] [R3] [R5]
		end
	end

	// registered readback, unmapped addresses read zero
	always_ff @(posedge clock) begin
		if (rst) begin
			sfr_rdata_ff <= 8'h00;
		end else if (sfr_req.rd && reg_hit) begin
			sfr_rdata_ff <= {halt_ff, lock_ff, rsvd_ff, fast_irq_response_ff, cd_ff}; // [R9]
		end else if (sfr_req.rd) begin
			sfr_rdata_ff <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core divider; new setting only taken when a period ends
	always_ff @(posedge clock) begin
		if (rst) begin
			core_cnt_ff <= 7'h00;
			core_div_ff <= CLOCK_CONTROL_RESET[BIT_DIV_HI:0]; // [R2]
			core_tick_ff <= 1'b0;
		end else if (core_wrap) begin
			core_cnt_ff <= 7'h00;
			core_div_ff <= nxt_div; // [R14] [R3]
			core_tick_ff <= 1'b1;
		end else begin
			core_cnt_ff <= core_cnt_ff + 7'h01;
			core_tick_ff <= 1'b0;
		end
	end

	// modulator tick every 512 PLL cycles; a whole multiple of every core period
	always_ff @(posedge clock) begin
		if (rst) begin
			mod_cnt_ff <= 9'h000;
			mod_tick_ff <= 1'b0;
		end else begin
			mod_cnt_ff <= mod_cnt_ff + 9'h001; // [R4] [R1]
			mod_tick_ff <= (mod_cnt_ff == MOD_LAST);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator gating in power-down
	always_ff @(posedge clock) begin
		if (rst) begin
			osc_run_ff <= 1'b1;
		end else begin
			osc_run_ff <= ~(powerdown && halt_ff); // [R7] [R8]
		end
	end

	// lock: crystal period in PLL cycles must sit near 512
	always_ff @(posedge clock) begin
		if (rst) begin
			period_ff <= 10'h000;
			lock_ff <= CLOCK_CONTROL_RESET[BIT_LOCK];
			pll_railed_ff <= 1'b0;
		end else if (xtal_rise) begin
			period_ff <= 10'h000;
			lock_ff <= in_window; // [R10] [R11]
			pll_railed_ff <= 1'b0;
		end else if (period_ff == PERIOD_TIMEOUT) begin
			// crystal gone: loop rails, flag drops
			lock_ff <= 1'b0; // [R11]
			pll_railed_ff <= 1'b1; // [R10]
		end else begin
			period_ff <= period_ff + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// helper state for the checks below
	logic [6:0] chk_cgap_ff;
	logic [2:0] chk_last_div_ff;
	logic chk_cseen_ff;
	logic [8:0] chk_mgap_ff;
	logic chk_mseen_ff;

	always_ff @(posedge clock) begin
		if (rst) begin
			chk_cgap_ff <= 7'h00;
			chk_last_div_ff <= 3'h0;
			chk_cseen_ff <= 1'b0;
			chk_mgap_ff <= 9'h000;
			chk_mseen_ff <= 1'b0;
		end else begin
			chk_cgap_ff <= core_tick_ff ? 7'h00 : chk_cgap_ff + 7'h01;
			if (core_tick_ff) begin
				chk_last_div_ff <= core_div_ff;
				chk_cseen_ff <= 1'b1;
			end
			chk_mgap_ff <= mod_tick_ff ? 9'h000 : chk_mgap_ff + 9'h001;
			if (mod_tick_ff) begin
				chk_mseen_ff <= 1'b1;
			end
		end
	end

	property p_reset_div;
		@(posedge clock) $fell(rst) |->
			core_div_ff == CLOCK_CONTROL_RESET[BIT_DIV_HI:0] &&
			cd_ff == CLOCK_CONTROL_RESET[BIT_DIV_HI:0];
	endproperty
	a_reset_div: assert property (p_reset_div) // [R2]
		else $error("divider not at divide-by-8 after reset");

	property p_core_period;
		@(posedge clock) disable iff (rst)
		core_tick_ff && chk_cseen_ff |->
			chk_cgap_ff == pcc_div_mask(chk_last_div_ff);
	endproperty
	a_core_period: assert property (p_core_period) // [R14]
		else $error("core period does not match the divider in force");

	property p_mod_period;
		@(posedge clock) disable iff (rst)
		mod_tick_ff && chk_mseen_ff |-> chk_mgap_ff == MOD_LAST;
	endproperty
	a_mod_period: assert property (p_mod_period) // [R4]
		else $error("modulator tick spacing is not 512 cycles");

	property p_fast_irq;
		@(posedge clock) disable iff (rst)
		core_tick_ff && $past(fast_irq_response_ff) && $past(irq_active) |->
			core_div_ff == 3'h0;
	endproperty
	a_fast_irq: assert property (p_fast_irq) // [R13]
		else $error("interrupt service not at fastest clock");

	property p_div_write;
		@(posedge clock) disable iff (rst)
		sfr_req.wr && reg_hit |=> cd_ff == $past(sfr_req.wdata[BIT_DIV_HI:0]);
	endproperty
	a_div_write: assert property (p_div_write) // [R12]
		else $error("divider field did not take the written value");

	property p_osc_halt;
		@(posedge clock) disable iff (rst)
		powerdown && halt_ff |=> !osc_run_ff;
	endproperty
	a_osc_halt: assert property (p_osc_halt) // [R7]
		else $error("oscillator kept running with halt set");

	property p_osc_keep;
		@(posedge clock) disable iff (rst)
		!halt_ff |=> osc_run_ff;
	endproperty
	a_osc_keep: assert property (p_osc_keep) // [R8]
		else $error("oscillator stopped with halt clear");

	property p_lock_ro;
		@(posedge clock) disable iff (rst)
		sfr_req.wr && reg_hit && !xtal_rise && period_ff != PERIOD_TIMEOUT
			|=> $stable(lock_ff);
	endproperty
	a_lock_ro: assert property (p_lock_ro) // [R9]
		else $error("write changed the lock flag");

	property p_lock_loss;
		@(posedge clock) disable iff (rst)
		period_ff == PERIOD_TIMEOUT && !xtal_rise |=> !lock_ff && pll_railed_ff;
	endproperty
	a_lock_loss: assert property (p_lock_loss) // [R11]
		else $error("lock held with no crystal edges");

	property p_lock_set;
		@(posedge clock) disable iff (rst)
		xtal_rise && in_window |=> lock_ff;
	endproperty
	a_lock_set: assert property (p_lock_set) // [R10]
		else $error("lock not set on an in-range crystal period");

endmodule

// *** verif/pcc_xtal_model.sv ***
// crystal model: square wave at 1/512 of the pll clock
`timescale 1ns/100ps
module pcc_xtal_model (
	// clock
	input wire logic clock,
	// crystal state
	input wire logic present,
	input wire logic osc_run,
	// crystal pin
	output logic xtal_in
);
	logic [8:0] phase_ff;
	initial phase_ff = 9'h000;
	// halted crystal leaves the pin still; a pulled crystal leaves it
	// floating, shown as the inverse of its last level
	always @(posedge clock) begin
		if (present && osc_run) begin
			phase_ff <= phase_ff + 9'h001;
		end
	end
	assign xtal_in = present ? phase_ff[8] : ~phase_ff[8];
endmodule

// *** verif/tb_pll_core_clock_control.sv ***
// testbench for the pll core clock control block
`timescale 1ns/100ps
module tb_pll_core_clock_control;
	import pcc_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	pcc_sfr_req_t sfr_req = '0;
	logic irq_active = 1'b0;
	logic powerdown = 1'b0;
	logic present = 1'b1;
	logic xtal_in, core_tick_ff, mod_tick_ff, osc_run_ff, pll_railed_ff;
	logic [7:0] sfr_rdata_ff;
	logic [2:0] core_div_ff;
	int gap;
	int num_errors = 0;
	int total_checks = 0;

	always #4 clock = ~clock;

	pcc_clock_control u_dut (.clock(clock), .rst(rst), .sfr_req(sfr_req),
		.sfr_rdata_ff(sfr_rdata_ff), .irq_active(irq_active),
		.powerdown(powerdown), .xtal_in(xtal_in),
		.core_tick_ff(core_tick_ff), .core_div_ff(core_div_ff),
		.mod_tick_ff(mod_tick_ff), .osc_run_ff(osc_run_ff),
		.pll_railed_ff(pll_railed_ff));
	pcc_xtal_model u_xtal (.clock(clock), .present(present),
		.osc_run(osc_run_ff), .xtal_in(xtal_in));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one strobe cycle; read data is settled when the task returns
	task automatic sfr_access(input logic wr, input logic [7:0] addr,
		input logic [7:0] data);
		@(negedge clock);
		sfr_req = '{addr: addr, wr: wr, rd: !wr, wdata: data};
		@(negedge clock);
		sfr_req = '0;
		@(negedge clock);
	endtask

	function automatic logic tick_of(input bit sel);
		return sel ? mod_tick_ff : core_tick_ff;
	endfunction

	// cycles between two ticks, bounded so a dead divider cannot hang
	task automatic measure(input bit sel, output int n);
		n = 0;
		do begin @(negedge clock); n++; end
		while (tick_of(sel) !== 1'b1 && n < 2000);
		n = 0;
		do begin @(negedge clock); n++; end
		while (tick_of(sel) !== 1'b1 && n < 2000);
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		$display("ERROR watchdog expected done seen timeout");
		end_of_test();
	end

	initial begin
		repeat (5) @(negedge clock);
		rst = 1'b0;
		sfr_access(1'b0, CLOCK_CONTROL_REG_ADDR, 8'h00);
		check("reset reg", 16'(sfr_rdata_ff), 16'(CLOCK_CONTROL_RESET));
		check("reset div", 16'(core_div_ff), 16'h0003);
		measure(1'b0, gap);
		check("reset period", 16'(gap), 16'h0008);
		measure(1'b1, gap);
		check("mod period", 16'(gap), 16'(XTAL_MULT));
		repeat (1100) @(negedge clock);
		// reserved bits set and lock bit written low on every pass
		for (int d = 0; d < 8; d++) begin
			sfr_access(1'b1, CLOCK_CONTROL_REG_ADDR, {5'h06, 3'(d)});
			sfr_access(1'b0, CLOCK_CONTROL_REG_ADDR, 8'h00);
			check("reg rd", 16'(sfr_rdata_ff), 16'({5'h0E, 3'(d)}));
			measure(1'b0, gap);
			measure(1'b0, gap);
			check("core period", 16'(gap), 16'(1 << d));
			check("div", 16'(core_div_ff), 16'(d));
		end
		sfr_access(1'b1, CLOCK_CONTROL_REG_ADDR, 8'h0B);
		irq_active = 1'b1;
		measure(1'b0, gap);
		measure(1'b0, gap);
		check("irq period", 16'(gap), 16'h0001);
		irq_active = 1'b0;
		measure(1'b0, gap);
		measure(1'b0, gap);
		check("post irq period", 16'(gap), 16'h0008);
		sfr_access(1'b1, 8'hD6, 8'hFF);
		sfr_access(1'b0, 8'hD6, 8'h00);
		check("unmapped rd", 16'(sfr_rdata_ff), 16'h0000);
		sfr_access(1'b1, CLOCK_CONTROL_REG_ADDR, 8'h03);
		powerdown = 1'b1;
		repeat (2) @(negedge clock);
		check("osc run pd", 16'(osc_run_ff), 16'h0001);
		sfr_access(1'b1, CLOCK_CONTROL_REG_ADDR, 8'h83);
		check("osc halt pd", 16'(osc_run_ff), 16'h0000);
		powerdown = 1'b0;
		repeat (2) @(negedge clock);
		check("osc run", 16'(osc_run_ff), 16'h0001);
		present = 1'b0;
		repeat (1100) @(negedge clock);
		sfr_access(1'b0, CLOCK_CONTROL_REG_ADDR, 8'h00);
		check("unlocked reg", 16'(sfr_rdata_ff), 16'h0083);
		check("railed", 16'(pll_railed_ff), 16'h0001);
		// mid-run reset while no crystal edges can move the lock flag
		rst = 1'b1;
		repeat (5) @(negedge clock);
		rst = 1'b0;
		sfr_access(1'b0, CLOCK_CONTROL_REG_ADDR, 8'h00);
		check("rst reg", 16'(sfr_rdata_ff), 16'(CLOCK_CONTROL_RESET));
		check("rst railed", 16'(pll_railed_ff), 16'h0000);
		present = 1'b1;
		repeat (1100) @(negedge clock);
		sfr_access(1'b0, CLOCK_CONTROL_REG_ADDR, 8'h00);
		check("relocked reg", 16'(sfr_rdata_ff), 16'h0053);
		check("unrailed", 16'(pll_railed_ff), 16'h0000);
		end_of_test();
	end
endmodule
